// file: hdl/rsc_defines.vh
// Constants of the rail strobe sequencer: register map, fields, resets, timing.
// Assumes inclusion by bare name from the sequencer core.
`ifndef RSC_DEFINES_VH
`define RSC_DEFINES_VH

// ----------------------------------------
// Register subaddresses
// ----------------------------------------
`define RSC_ADDR_LDO_VOLT 8'h1B
`define RSC_ADDR_GAP_LOW 8'h20
`define RSC_ADDR_GAP_HIGH 8'h21
`define RSC_ADDR_BUCK12 8'h22
`define RSC_ADDR_BUCK34 8'h23
`define RSC_ADDR_UNLOCK 8'h10

// ----------------------------------------
// Reset values and field layout
// ----------------------------------------
`define RSC_RST_LDO_VOLT 6'h1F
`define RSC_RST_LDO_MV 12'h708
`define RSC_RST_GAP_LOW 8'h00
`define RSC_RST_GAP_HIGH_LSB 1'b0
`define RSC_RST_FACTOR 1'b0
`define RSC_RST_BUCK12 8'h55
`define RSC_RST_BUCK34 8'h37
`define RSC_FACTOR_BIT 7
`define RSC_GAP9_BIT 0
`define RSC_UNLOCK_KEY 8'h7D

// ----------------------------------------
// Strobe codes and voltage map
// ----------------------------------------
`define RSC_STROBE_FIRST 4'h1
`define RSC_STROBE_LAST 4'hA
`define RSC_CODE_MIN 4'h3
`define RSC_CODE_MAX 4'hA
`define RSC_LDO_FINE_TOP 6'h1A
`define RSC_LDO_BASE_MV 12'h384
`define RSC_LDO_COARSE_MV 12'h640
`define RSC_LDO_FINE_STEP 12'h019
`define RSC_LDO_COARSE_STEP 12'h032

// ----------------------------------------
// Timing
// ----------------------------------------
`define RSC_CLK_MHZ 200
`define RSC_US_PER_MS 1000
`define RSC_GAP_SHORT_MS 6'h02
`define RSC_GAP_LONG_MS 6'h05
`define RSC_DOWN_FACTOR 6'h0A
`define RSC_BLANK_MS 5

`endif

// file: hdl/rsc_sequencer.v
// Sequencer configuration registers, strobe timing and regulator code register.
// Assumes an on-chip serial-bus slave presents single-cycle register strobes on
// the clk_in domain, and power-up/down requests come from same-clock logic.
`timescale 1ns/1ps
`include "rsc_defines.vh"

module rsc_sequencer #(
    parameter CYC_PER_MS = `RSC_CLK_MHZ * `RSC_US_PER_MS,
    parameter BLANK_CYC = `RSC_BLANK_MS * `RSC_CLK_MHZ * `RSC_US_PER_MS
) (
    input wire clk_in,
    input wire reset_n_in,
    input wire [7:0] reg_addr_in,
    input wire [7:0] reg_wdata_in,
    input wire reg_wr_in,
    input wire reg_rd_in,
    input wire power_up_req_in,
    input wire power_down_req_in,
    output wire [7:0] reg_rdata_out,
    output wire write_refused_out,
    output wire [5:0] ldo_code_out,
    output wire [11:0] ldo_mv_out,
    output wire monitor_blank_out,
    output wire buck_one_en_out,
    output wire buck_two_en_out,
    output wire [3:0] strobe_num_out,
    output wire strobe_pulse_out,
    output wire seq_busy_out
);

    localparam ST_IDLE = 2'b00;
    localparam ST_UP = 2'b01;
    localparam ST_DOWN = 2'b10;

    // ----------------------------------------
    // Helpers
    // ----------------------------------------
    function [11:0] ldo_mv;
        input [5:0] code;
        begin
            if (code <= `RSC_LDO_FINE_TOP) begin
                ldo_mv = `RSC_LDO_BASE_MV + `RSC_LDO_FINE_STEP * {6'h00, code};
            end else begin
                ldo_mv = `RSC_LDO_COARSE_MV
                    + `RSC_LDO_COARSE_STEP * ({6'h00, code} - 12'h01B);
            end
        end
    endfunction

    // Gap in ms following strobe idx (1..9) in ascending numbering
    function [5:0] gap_ms;
        input [3:0] idx;
        input [7:0] low;
        input gap9;
        input scale;
        reg sel;
        begin
            // Index 0 or above 9 selects the short gap; keep the select in range
            sel = (idx == 4'h9) ? gap9 : ((idx == 4'h0 || idx > 4'h9) ? 1'b0
                : low[idx[2:0] - 3'h1]);
            gap_ms = sel ? `RSC_GAP_LONG_MS : `RSC_GAP_SHORT_MS;
            if (scale) begin
                gap_ms = gap_ms * `RSC_DOWN_FACTOR;
            end
        end
    endfunction

    function rail_next;
        input [3:0] field;
        input [3:0] strobe;
        input up;
        input cur;
        begin
            if (field >= `RSC_CODE_MIN && field <= `RSC_CODE_MAX && field == strobe) begin
                rail_next = up;
            end else begin
                rail_next = cur;
            end
        end
    endfunction

    // ----------------------------------------
    // Registers
    // ----------------------------------------
    reg [5:0] ldo_code_ff;
    reg [7:0] gap_low_ff;
    reg gap9_ff;
    reg factor_ff;
    reg [7:0] buck12_ff;
    reg [7:0] buck34_ff;
    reg unlocked_ff;
    reg [7:0] rdata_ff;
    reg refused_ff;
    reg [11:0] ldo_mv_ff;
    reg [31:0] blank_cnt_ff;
    reg blank_ff;
    reg [1:0] state_ff;
    reg [3:0] strobe_ff;
    reg [5:0] ms_left_ff;
    reg [31:0] div_ff;
    reg pulse_ff;
    reg buck1_ff;
    reg buck2_ff;
    reg busy_ff;

    wire is_prot = (reg_addr_in == `RSC_ADDR_LDO_VOLT) || (reg_addr_in == `RSC_ADDR_GAP_LOW)
        || (reg_addr_in == `RSC_ADDR_GAP_HIGH) || (reg_addr_in == `RSC_ADDR_BUCK12)
        || (reg_addr_in == `RSC_ADDR_BUCK34);
    wire wr_ok = reg_wr_in && is_prot && unlocked_ff;
    wire ldo_wr = wr_ok && (reg_addr_in == `RSC_ADDR_LDO_VOLT);

    // ----------------------------------------
    // Register writes and unlock
    // ----------------------------------------
    // The key arms exactly one following write; any other write relocks.
    always @(posedge clk_in) begin
        if (!reset_n_in) begin
            ldo_code_ff <= `RSC_RST_LDO_VOLT;
            gap_low_ff <= `RSC_RST_GAP_LOW;
            gap9_ff <= `RSC_RST_GAP_HIGH_LSB;
            factor_ff <= `RSC_RST_FACTOR;
            buck12_ff <= `RSC_RST_BUCK12;
            buck34_ff <= `RSC_RST_BUCK34;
            unlocked_ff <= 1'b0;
            refused_ff <= 1'b0;
        end else begin
            refused_ff <= reg_wr_in && is_prot && !unlocked_ff;
            if (reg_wr_in) begin
                unlocked_ff <= (reg_addr_in == `RSC_ADDR_UNLOCK)
                    && (reg_wdata_in == `RSC_UNLOCK_KEY);
            end
            if (wr_ok) begin
                case (reg_addr_in)
                    `RSC_ADDR_LDO_VOLT: ldo_code_ff <= reg_wdata_in[5:0];
                    `RSC_ADDR_GAP_LOW: gap_low_ff <= reg_wdata_in;
                    `RSC_ADDR_GAP_HIGH: begin
                        factor_ff <= reg_wdata_in[`RSC_FACTOR_BIT];
                        gap9_ff <= reg_wdata_in[`RSC_GAP9_BIT];
                    end
                    `RSC_ADDR_BUCK12: buck12_ff <= reg_wdata_in;
                    `RSC_ADDR_BUCK34: buck34_ff <= reg_wdata_in;
                    default: ;
                endcase
            end
        end
    end

    // ----------------------------------------
    // Read port, one cycle latency
    // ----------------------------------------
    always @(posedge clk_in) begin
        if (!reset_n_in) begin
            rdata_ff <= 8'h00;
        end else if (reg_rd_in) begin
            case (reg_addr_in)
                `RSC_ADDR_LDO_VOLT: rdata_ff <= {2'b00, ldo_code_ff};
                `RSC_ADDR_GAP_LOW: rdata_ff <= gap_low_ff;
                `RSC_ADDR_GAP_HIGH: rdata_ff <= {factor_ff, 6'h00, gap9_ff};
                `RSC_ADDR_BUCK12: rdata_ff <= buck12_ff;
                `RSC_ADDR_BUCK34: rdata_ff <= buck34_ff;
                default: rdata_ff <= 8'h00;
            endcase
        end
    end

    // ----------------------------------------
    // Regulator voltage and monitor blanking
    // ----------------------------------------
    // A code write during blanking restarts the full window.
    always @(posedge clk_in) begin
        if (!reset_n_in) begin
            ldo_mv_ff <= `RSC_RST_LDO_MV;
            blank_cnt_ff <= 32'h00000000;
            blank_ff <= 1'b0;
        end else begin
            ldo_mv_ff <= ldo_mv(ldo_code_ff);
            if (ldo_wr) begin
                blank_cnt_ff <= BLANK_CYC - 1;
                blank_ff <= 1'b1;
            end else if (blank_cnt_ff != 32'h00000000) begin
                blank_cnt_ff <= blank_cnt_ff - 32'h00000001;
            end else begin
                blank_ff <= 1'b0;
            end
        end
    end

    // ----------------------------------------
    // Strobe sequencer
    // ----------------------------------------
    reg [1:0] nxt_state;
    reg [3:0] nxt_strobe;
    reg [5:0] nxt_ms_left;
    reg nxt_apply;
    wire tick = (div_ff == CYC_PER_MS - 1);

    always @* begin
        nxt_state = state_ff;
        nxt_strobe = strobe_ff;
        nxt_ms_left = ms_left_ff;
        nxt_apply = 1'b0;
        case (state_ff)
            ST_IDLE: begin
                if (power_up_req_in) begin
                    nxt_state = ST_UP;
                    nxt_strobe = `RSC_STROBE_FIRST;
                    nxt_apply = 1'b1;
                end else if (power_down_req_in) begin
                    nxt_state = ST_DOWN;
                    nxt_strobe = `RSC_STROBE_LAST;
                    nxt_apply = 1'b1;
                end
            end
            ST_UP, ST_DOWN: begin
                if (tick) begin
                    nxt_ms_left = ms_left_ff - 6'h01;
                    if (ms_left_ff == 6'h01) begin
                        nxt_strobe = (state_ff == ST_UP) ? strobe_ff + 4'h1
                            : strobe_ff - 4'h1;
                        nxt_apply = 1'b1;
                    end
                end
            end
            default: nxt_state = ST_IDLE;
        endcase
        if (nxt_apply) begin
            if (nxt_state == ST_UP) begin
                nxt_ms_left = gap_ms(nxt_strobe, gap_low_ff, gap9_ff, 1'b0);
            end else begin
                nxt_ms_left = gap_ms(nxt_strobe - 4'h1, gap_low_ff, gap9_ff,
                    factor_ff);
            end
        end
    end

    // Sequence ends on the strobe itself; no gap follows the last one.
    always @(posedge clk_in) begin
        if (!reset_n_in) begin
            state_ff <= ST_IDLE;
            strobe_ff <= 4'h0;
            ms_left_ff <= 6'h00;
            div_ff <= 32'h00000000;
            pulse_ff <= 1'b0;
            buck1_ff <= 1'b0;
            buck2_ff <= 1'b0;
            busy_ff <= 1'b0;
        end else begin
            strobe_ff <= nxt_strobe;
            ms_left_ff <= nxt_ms_left;
            pulse_ff <= nxt_apply;
            div_ff <= (nxt_apply || tick) ? 32'h00000000 : div_ff + 32'h00000001;
            state_ff <= nxt_state;
            busy_ff <= (nxt_state != ST_IDLE);
            if (nxt_apply) begin
                buck1_ff <= rail_next(buck12_ff[3:0], nxt_strobe, nxt_state == ST_UP,
                    buck1_ff);
                buck2_ff <= rail_next(buck12_ff[7:4], nxt_strobe, nxt_state == ST_UP,
                    buck2_ff);
                if ((nxt_state == ST_UP && nxt_strobe == `RSC_STROBE_LAST)
                    || (nxt_state == ST_DOWN && nxt_strobe == `RSC_STROBE_FIRST)) begin
                    state_ff <= ST_IDLE;
                    busy_ff <= 1'b0;
                end
            end
        end
    end

    assign reg_rdata_out = rdata_ff;
    assign write_refused_out = refused_ff;
    assign ldo_code_out = ldo_code_ff;
    assign ldo_mv_out = ldo_mv_ff;
    assign monitor_blank_out = blank_ff;
    assign buck_one_en_out = buck1_ff;
    assign buck_two_en_out = buck2_ff;
    assign strobe_num_out = strobe_ff;
    assign strobe_pulse_out = pulse_ff;
    assign seq_busy_out = busy_ff;

endmodule

// file: verification/rsc_sequencer_sva.sv
// Assertion checker of the strobe sequencer core, bound onto its ports.
// Assumes short sim counts: at least 8 blanking cycles, 5 cycles per ms.
`timescale 1ns/1ps
module rsc_sequencer_sva #(
    parameter CYC_PER_MS = 10,
    parameter BLANK_CYC = 50
) (
    input wire clk_in,
    input wire reset_n_in,
    input wire [7:0] reg_addr_in,
    input wire reg_wr_in,
    input wire reg_rd_in,
    input wire [7:0] reg_rdata_out,
    input wire write_refused_out,
    input wire [5:0] ldo_code_out,
    input wire [11:0] ldo_mv_out,
    input wire monitor_blank_out,
    input wire buck_one_en_out,
    input wire buck_two_en_out,
    input wire [3:0] strobe_num_out,
    input wire strobe_pulse_out,
    input wire seq_busy_out
);
    reg [31:0] blank_len_ff;
    function automatic [11:0] rsc_mv(input [5:0] c);
        rsc_mv = (c <= 6'h1A) ? 12'h384 + 12'h019 * c : 12'h640 + 12'h032 * (c - 6'h1B);
    endfunction
    // ----------------------------------------
    // Properties
    // ----------------------------------------
    // Length of the current blanking window
    always @(posedge clk_in)
        blank_len_ff <= (!reset_n_in || !monitor_blank_out) ? 32'h0 : blank_len_ff + 32'h1;
    default clocking @(posedge clk_in); endclocking
    default disable iff (!reset_n_in);
    property p_mv; 1'b1 |=> ldo_mv_out == rsc_mv($past(ldo_code_out)); endproperty
    a_mv: assert property (p_mv) else $error("voltage value off its code");
    property p_ldo_rsv; reg_rd_in && reg_addr_in == 8'h1B |=> reg_rdata_out[7:6] == 2'b00; endproperty
    a_ldo_rsv: assert property (p_ldo_rsv) else $error("code read upper bits set");
    property p_code; !$stable(ldo_code_out) |-> $past(reg_wr_in) && $past(reg_addr_in) == 8'h1B;
    endproperty
    a_code: assert property (p_code) else $error("code moved without a write");
    property p_bl_rise; $rose(monitor_blank_out) |-> $past(reg_wr_in) && $past(reg_addr_in) == 8'h1B;
    endproperty
    a_bl_rise: assert property (p_bl_rise) else $error("blanking without code write");
    property p_bl_len; $fell(monitor_blank_out) |-> blank_len_ff == BLANK_CYC; endproperty
    a_bl_len: assert property (p_bl_len) else $error("blanking length wrong");
    property p_strobe; !$stable(strobe_num_out) |-> strobe_pulse_out; endproperty
    a_strobe: assert property (p_strobe) else $error("strobe moved without pulse");
    property p_rail; !$stable({buck_one_en_out, buck_two_en_out}) |-> strobe_pulse_out; endproperty
    a_rail: assert property (p_rail) else $error("rail moved off a strobe");
    property p_gap; strobe_pulse_out && seq_busy_out |=> !strobe_pulse_out [*8]; endproperty
    a_gap: assert property (p_gap) else $error("strobes too close");
    c_top: cover property (strobe_pulse_out && strobe_num_out == 4'hA);
    c_refuse: cover property (write_refused_out);
    c_blank: cover property ($rose(monitor_blank_out));
endmodule
bind rsc_sequencer rsc_sequencer_sva #(.CYC_PER_MS(CYC_PER_MS), .BLANK_CYC(BLANK_CYC)) u_sva (
    .clk_in(clk_in), .reset_n_in(reset_n_in), .reg_addr_in(reg_addr_in),
    .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in), .reg_rdata_out(reg_rdata_out),
    .write_refused_out(write_refused_out), .ldo_code_out(ldo_code_out),
    .ldo_mv_out(ldo_mv_out), .monitor_blank_out(monitor_blank_out),
    .buck_one_en_out(buck_one_en_out), .buck_two_en_out(buck_two_en_out),
    .strobe_num_out(strobe_num_out), .strobe_pulse_out(strobe_pulse_out),
    .seq_busy_out(seq_busy_out));

// file: verification/testbench.sv
// Self-checking bench of the strobe sequencer core: registers, timing, rails.
// Assumes the core's include directory is on the search path.
`timescale 1ns/1ps
`include "rsc_defines.vh"
module testbench;
localparam C = 10;
localparam B = 50;
localparam logic [7:0] A [6] = '{8'h20, 8'h21, 8'h22, 8'h23, 8'h1B, 8'h10};
localparam logic [7:0] V [6] = '{8'h00, 8'h00, 8'h55, 8'h37, 8'h1F, 8'h00};
logic clk_in = 0, reset_n_in = 0, wr = 0, rd = 0, up = 0, dn = 0, pend = 0, e1 = 0, e2 = 0;
logic [7:0] ad = 0, wd = 0, rdata;
logic [11:0] mv;
logic [5:0] code;
logic refd, blank, b1, b2, pls, busy;
logic [3:0] num;
logic [7:0] rq[$];
logic [6:0] sq[$];
int gq[$];
int error_cnt = 0, total_checks = 0, cyc = 0, last = 0, seed = 32'h0aacffc7;
always #2.5 clk_in = ~clk_in;
rsc_sequencer #(.CYC_PER_MS(C), .BLANK_CYC(B)) dut (.clk_in(clk_in), .reset_n_in(reset_n_in),
    .reg_addr_in(ad), .reg_wdata_in(wd), .reg_wr_in(wr), .reg_rd_in(rd), .power_up_req_in(up),
    .power_down_req_in(dn), .reg_rdata_out(rdata), .write_refused_out(refd),
    .ldo_code_out(code), .ldo_mv_out(mv), .monitor_blank_out(blank), .buck_one_en_out(b1),
    .buck_two_en_out(b2), .strobe_num_out(num), .strobe_pulse_out(pls), .seq_busy_out(busy));
task chk(input logic [11:0] g, input logic [11:0] e);
    total_checks++;
    if (g !== e) begin
        error_cnt++;
        $display("BAD %0t got %h want %h", $time, g, e);
    end
endtask
task summarize;
    $display("TB: checks %0d errors %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0)
        $display("TB: PASS");
    else
        $display("TB: FAIL");
    $finish;
endtask
// ----------------------------------------
// Result watcher and hang guard
// ----------------------------------------
always @(posedge clk_in) begin
    cyc <= cyc + 1;
    if (cyc == 80000) begin
        error_cnt++;
        summarize;
    end
end
// Read data lands one cycle after the taken edge
always @(negedge clk_in) begin
    if (pend) chk({4'h0, rdata}, {4'h0, rq.pop_front()});
    pend <= rd;
    if (pls) begin
        chk({5'h00, num, b1, b2, busy}, {5'h00, sq.pop_front()});
        if (gq[0] != 0) chk(12'(cyc - last), 12'(gq[0]));
        void'(gq.pop_front());
        last = cyc;
    end
end
task w(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_in);
    wr <= 1;
    ad <= a;
    wd <= d;
    @(posedge clk_in);
    wr <= 0;
endtask
task pw(input logic [7:0] a, input logic [7:0] d);
    w(8'h10, `RSC_UNLOCK_KEY);
    w(a, d);
endtask
task r(input logic [7:0] a, input logic [7:0] e);
    rq.push_back(e);
    @(posedge clk_in);
    rd <= 1;
    ad <= a;
    @(posedge clk_in);
    rd <= 0;
endtask
task ldo(input logic [5:0] c);
    int n;
    pw(8'h1B, {2'b11, c});
    @(negedge clk_in);
    chk({11'h000, blank}, 12'h001);
    @(negedge clk_in);
    n = 1;
    chk(mv, c <= 6'h1A ? 12'h384 + 12'h019 * c : 12'h640 + 12'h032 * (c - 6'h1B));
    chk({6'h00, code}, {6'h00, c});
    while (blank === 1'b1 && n < 200) begin
        @(negedge clk_in);
        n++;
    end
    chk(12'(n), 12'(B));
    r(8'h1B, {2'b00, c});
endtask
// Queue the ten strobes of one sequence, then request it
task seq(input logic u, input logic [7:0] lo, input logic [7:0] hi, input logic [7:0] f);
    int n, g, i;
    for (i = 1; i <= 10; i++) begin
        n = u ? i : 11 - i;
        g = u ? n - 1 : n;
        if (n >= 3 && f[3:0] == n) e1 = u;
        if (n >= 3 && f[7:4] == n) e2 = u;
        sq.push_back({n[3:0], e1, e2, i != 10});
        g = (g < 1 || g > 9) ? 0 : ((g < 9 ? lo[g-1] : hi[0]) ? 5 : 2);
        gq.push_back(g * C * ((!u && hi[7]) ? 10 : 1));
    end
    @(posedge clk_in);
    if (u) up <= 1;
    else dn <= 1;
    @(posedge clk_in);
    up <= 0;
    dn <= 0;
    while (sq.size() > 0) @(posedge clk_in);
endtask
initial begin
    logic [7:0] lo, hi, f;
    int k;
    repeat (8) @(posedge clk_in);
    reset_n_in <= 1;
    for (k = 0; k < 6; k++) r(A[k], V[k]);
    w(8'h22, 8'h00);
    @(negedge clk_in);
    chk({11'h000, refd}, 12'h001);
    r(8'h22, 8'h55);
    $display("TB: reset and lock done");
    for (k = 0; k < 4; k++) ldo(k[1] ? (k[0] ? 6'h3F : 6'h1B) : (k[0] ? 6'h1A : 6'h00));
    $display("TB: regulator done");
    for (k = 0; k < 16; k++) begin
        lo = $random(seed);
        hi = {k[0], 6'h3F, lo[3]};
        f = {4'(15 - k), 4'(k)};
        pw(8'h20, lo);
        pw(8'h21, hi);
        pw(8'h22, f);
        r(8'h21, hi & 8'h81);
        seq(1, lo, hi, f);
        seq(0, lo, hi, f);
        $display("TB: sequence %0d done", k);
    end
    summarize;
end
endmodule
